// ==== hdl/lcs_consts.svh ====
// constants for the logic channel sampler: offsets, fields, resets, timing
//
// Operation
// - sixteen channels in two pods of eight
// - four groups, each from selectable channels
// - enabling overlapping group disables other, raises notice
// - above threshold stores one, below stores zero
// - hysteresis normal, maximum or robust per group
// - coupling on after reset: one threshold everywhere
// - enabled groups share last enabled group's threshold
// - preset loads all; direct threshold write means manual
// - unclocked every sample, clocked only at edges
// - bus clock taken from selectable channel
// - selectable clock slope captures all group channels
// - one decoded word plus timestamp per edge
// - integer word at most sixteen bits, two's complement
// - programmable delay per channel
// - programmable common delay on top
// - fixed pod versus analog offset compensated automatically
// - one control adds or drops whole pod
`ifndef LCS_CONSTS_SVH
`define LCS_CONSTS_SVH

// -------------------------------------------------------------
// register offsets
// -------------------------------------------------------------
`define LCS_A_STATUS   6'h00
`define LCS_A_COUPLE   6'h01
`define LCS_A_PRESET   6'h02
`define LCS_A_CSKEW    6'h03
`define LCS_A_DROP     6'h04
`define LCS_A_POD      6'h05
`define LCS_G_CTRL     2'h0
`define LCS_G_MASK     2'h1
`define LCS_G_THR      2'h2
`define LCS_G_TRACE    2'h3

// -------------------------------------------------------------
// field positions
// -------------------------------------------------------------
`define LCS_ST_NOTICE  0
`define LCS_ST_MANUAL  1
`define LCS_ST_EN_LSB  8
`define LCS_C_EN       0
`define LCS_C_CLKD     1
`define LCS_C_RISE     2
`define LCS_C_SGN      3
`define LCS_C_SRC_LSB  4
`define LCS_T_HYS_LSB  8
`define LCS_P_POD1_SET 2
`define LCS_P_POD1_CLR 3
`define LCS_P_POD2_SET 4
`define LCS_P_POD2_CLR 5

// -------------------------------------------------------------
// reset values, thresholds and hysteresis in input codes
// -------------------------------------------------------------
`define LCS_THR_RST    8'h40
`define LCS_PRESET_RST 2'h1
`define LCS_PRE1_THR   8'h40
`define LCS_PRE2_THR   8'h60
`define LCS_PRE3_THR   8'h20
`define LCS_HYS_NORM   8'h02
`define LCS_HYS_MAX    8'h10
`define LCS_HYS_RISE   8'h08
`define LCS_HYS_FALL   8'h02

// -------------------------------------------------------------
// timing in samples of one clock each, fifo depth in words
// -------------------------------------------------------------
`define LCS_SKEW_DEPTH 32
`define LCS_POD_ALIGN  3
`define LCS_FIFO_DEPTH 4

`endif

// ==== hdl/lcs_fifo.sv ====
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/10ps

module lcs_fifo #(
    parameter int W     = 34,
    parameter int DEPTH = 4
)(
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0]   cnt_r;
    logic          push;
    logic          pop;

    // full and empty come straight from the fill count
    assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rp_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    // pointers wrap at depth, which need not be a power of two
    always_ff @(posedge clk) begin
        if (reset) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + AW'(1);
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + AW'(1);
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ==== hdl/lcs_pkg.sv ====
// types shared by the logic channel sampler
package lcs_pkg;
    typedef enum logic [1:0] {
        LCS_HYS_NORMAL = 2'b00,
        LCS_HYS_MAXIMUM = 2'b01,
        LCS_HYS_ROBUST = 2'b10
    } lcs_hys_t;
    typedef logic [1:0] lcs_grp_t;
endpackage

// ==== hdl/lcs_sampler.sv ====
// logic channel sampler: threshold, skew, grouping and clocked-bus decode
`timescale 1ns/10ps
`include "lcs_consts.svh"

module lcs_sampler
    import lcs_pkg::*;
#(
    parameter int DEPTH     = `LCS_SKEW_DEPTH,
    parameter int POD_ALIGN = `LCS_POD_ALIGN,
    parameter int FDEPTH    = `LCS_FIFO_DEPTH
)(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [63:0] first_pod_lines,
    input  wire logic [63:0] second_pod_lines,
    input  wire logic [5:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [15:0]      reg_rdata,
    output logic [3:0][15:0] logic_group_trace,
    output logic             decode_valid,
    input  wire logic        decode_ready,
    output logic [1:0]       decode_group,
    output logic [15:0]      decode_word,
    output logic [15:0]      decode_time,
    output logic             notice
);
    localparam int FW = 34;

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    logic [127:0]   digital_input_lines;
    logic [3:0]     en_r;
    logic [3:0]     clkd_r;
    logic [3:0]     rise_r;
    logic [3:0]     sgn_r;
    logic [3:0]     src_r [4];
    logic [15:0]    mask_r [4];
    logic [7:0]     thr_r [4];
    lcs_hys_t       hys_r [4];
    lcs_grp_t       last_r;
    logic           couple_r;
    logic [1:0]     preset_r;
    logic           notice_r;
    logic [3:0]     skew_r [16];
    logic [3:0]     cskew_r;
    logic [15:0]    lvl_r;
    logic [15:0]    hist_r [DEPTH];
    logic [15:0]    aln_r;
    logic [3:0]     cprev_r;
    logic [15:0]    trace_r [4];
    logic [15:0]    ts_r;
    logic [15:0]    drop_r;
    logic [15:0]    rdata_r;
    logic           dv_r;
    logic [FW-1:0]  dout_r;
    logic [7:0]     eff_thr;
    logic [7:0]     hu;
    logic [7:0]     hd;
    logic [3:0]     edge_g;
    logic [15:0]    word_g [4];
    logic           push;
    logic           lost;
    lcs_grp_t       pg;
    logic           f_in_ready;
    logic           f_out_valid;
    logic           f_out_ready;
    logic [FW-1:0]  f_out_data;
    lcs_grp_t       wg;
    lcs_grp_t       pod_g;

    // both pods form one sixteen-channel bank, first pod low
    assign digital_input_lines = {second_pod_lines, first_pod_lines};
    assign wg    = reg_addr[3:2];
    assign pod_g = reg_wdata[1:0];

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    // gather selected levels ascending; optional sign extension
    function automatic logic [15:0] pack_word(input logic [15:0] sel,
                                              input logic [15:0] lv,
                                              input logic        sgn);
        logic [15:0] w;
        logic [4:0]  n;
        w = '0;
        n = '0;
        for (int i = 0; i < 16; i++) begin
            if (sel[i]) begin
                w[n[3:0]] = lv[i];
                n = n + 5'd1;
            end
        end
        // width never passes sixteen, so two's complement fills the rest
        if (sgn && n != 5'd0 && n != 5'd16) begin
            for (int i = 0; i < 16; i++) begin
                if (5'(i) >= n) begin
                    w[i] = w[n[3:0] - 4'd1];
                end
            end
        end
        return w;
    endfunction

    // total delay tap, saturated at the end of the history
    function automatic logic [4:0] tap(input logic [3:0] s,
                                       input logic [3:0] cs);
        logic [5:0] t;
        t = {2'b00, s} + {2'b00, cs} + 6'(POD_ALIGN);
        return (t > 6'(DEPTH-1)) ? 5'(DEPTH-1) : t[4:0];
    endfunction

    // logic family preset thresholds
    function automatic logic [7:0] preset_thr(input logic [1:0] p);
        case (p)
            2'd1:    preset_thr = `LCS_PRE1_THR;
            2'd2:    preset_thr = `LCS_PRE2_THR;
            2'd3:    preset_thr = `LCS_PRE3_THR;
            default: preset_thr = `LCS_THR_RST;
        endcase
    endfunction

    // -------------------------------------------------------------
    // configuration registers
    // -------------------------------------------------------------
    // only one write per cycle, so the notice set never meets its clear
    always_ff @(posedge clk) begin
        if (reset) begin
            en_r     <= '0;
            clkd_r   <= '0;
            rise_r   <= '0;
            sgn_r    <= '0;
            last_r   <= '0;
            couple_r <= 1'b1;
            preset_r <= `LCS_PRESET_RST;
            notice_r <= 1'b0;
            cskew_r  <= '0;
            for (int g = 0; g < 4; g++) begin
                src_r[g]  <= '0;
                mask_r[g] <= '0;
                thr_r[g]  <= `LCS_THR_RST;
                hys_r[g]  <= LCS_HYS_NORMAL;
            end
            for (int c = 0; c < 16; c++) begin
                skew_r[c] <= '0;
            end
        end else if (reg_wr) begin
            if (reg_addr == `LCS_A_STATUS && reg_wdata[`LCS_ST_NOTICE]) begin
                notice_r <= 1'b0;
            end
            if (reg_addr == `LCS_A_COUPLE) begin
                couple_r <= reg_wdata[0];
            end
            // a preset reaches every group at once
            if (reg_addr == `LCS_A_PRESET) begin
                preset_r <= reg_wdata[1:0];
                if (reg_wdata[1:0] != 2'd0) begin
                    for (int g = 0; g < 4; g++) begin
                        thr_r[g] <= preset_thr(reg_wdata[1:0]);
                    end
                end
            end
            if (reg_addr == `LCS_A_CSKEW) begin
                cskew_r <= reg_wdata[3:0];
            end
            if (reg_addr[5:4] == 2'b10) begin
                skew_r[reg_addr[3:0]] <= reg_wdata[3:0];
            end
            // whole-pod select into one disabled group
            if (reg_addr == `LCS_A_POD && !en_r[pod_g]) begin
                if (reg_wdata[`LCS_P_POD1_SET]) begin
                    mask_r[pod_g][7:0] <= 8'hff;
                end else if (reg_wdata[`LCS_P_POD1_CLR]) begin
                    mask_r[pod_g][7:0] <= 8'h00;
                end
                if (reg_wdata[`LCS_P_POD2_SET]) begin
                    mask_r[pod_g][15:8] <= 8'hff;
                end else if (reg_wdata[`LCS_P_POD2_CLR]) begin
                    mask_r[pod_g][15:8] <= 8'h00;
                end
            end
            if (reg_addr[5:4] == 2'b01) begin
                case (reg_addr[1:0])
                    `LCS_G_CTRL: begin
                        en_r[wg] <= reg_wdata[`LCS_C_EN];
                        // clock settings frozen while capturing
                        if (!en_r[wg]) begin
                            clkd_r[wg] <= reg_wdata[`LCS_C_CLKD];
                            rise_r[wg] <= reg_wdata[`LCS_C_RISE];
                            sgn_r[wg]  <= reg_wdata[`LCS_C_SGN];
                            src_r[wg]  <= reg_wdata[`LCS_C_SRC_LSB +: 4];
                        end
                        // newly enabled: evict overlapping groups
                        if (reg_wdata[`LCS_C_EN] && !en_r[wg]) begin
                            last_r <= wg;
                            for (int h = 0; h < 4; h++) begin
                                if (lcs_grp_t'(h) != wg && en_r[h]
                                    && (mask_r[h] & mask_r[wg]) != '0) begin
                                    en_r[h]  <= 1'b0;
                                    notice_r <= 1'b1;
                                end
                            end
                        end
                    end
                    `LCS_G_MASK: begin
                        if (!en_r[wg]) begin
                            mask_r[wg] <= reg_wdata;
                        end
                    end
                    `LCS_G_THR: begin
                        preset_r <= 2'd0;
                        for (int g = 0; g < 4; g++) begin
                            if (couple_r || lcs_grp_t'(g) == wg) begin
                                thr_r[g] <= reg_wdata[7:0];
                                hys_r[g] <= lcs_hys_t'(reg_wdata[`LCS_T_HYS_LSB +: 2]);
                            end
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // -------------------------------------------------------------
    // threshold comparison with hysteresis
    // -------------------------------------------------------------
    // every channel follows the group enabled last
    always_comb begin
        eff_thr = thr_r[last_r];
        case (hys_r[last_r])
            LCS_HYS_NORMAL: begin
                hu = `LCS_HYS_NORM;
                hd = `LCS_HYS_NORM;
            end
            LCS_HYS_MAXIMUM: begin
                hu = `LCS_HYS_MAX;
                hd = `LCS_HYS_MAX;
            end
            LCS_HYS_ROBUST: begin
                hu = `LCS_HYS_RISE;
                hd = `LCS_HYS_FALL;
            end
            default: begin
                hu = `LCS_HYS_NORM;
                hd = `LCS_HYS_NORM;
            end
        endcase
    end

    // nine-bit sums keep the band from wrapping at the code ends
    always_ff @(posedge clk) begin
        if (reset) begin
            lvl_r <= '0;
        end else begin
            for (int c = 0; c < 16; c++) begin
                if (!lvl_r[c]) begin
                    lvl_r[c] <= ({1'b0, digital_input_lines[c*8 +: 8]}
                                 > {1'b0, eff_thr} + {1'b0, hu});
                end else begin
                    lvl_r[c] <= !({1'b0, digital_input_lines[c*8 +: 8]} + {1'b0, hd}
                                  < {1'b0, eff_thr});
                end
            end
        end
    end

    // -------------------------------------------------------------
    // skew: history of levels, one tap per channel
    // -------------------------------------------------------------
    // depth bounds the sum of all delays; larger ones saturate
    always_ff @(posedge clk) begin
        if (reset) begin
            aln_r <= '0;
            for (int d = 0; d < DEPTH; d++) begin
                hist_r[d] <= '0;
            end
        end else begin
            hist_r[0] <= lvl_r;
            for (int d = 1; d < DEPTH; d++) begin
                hist_r[d] <= hist_r[d-1];
            end
            for (int c = 0; c < 16; c++) begin
                aln_r[c] <= hist_r[tap(skew_r[c], cskew_r)][c];
            end
        end
    end

    // -------------------------------------------------------------
    // group evaluation
    // -------------------------------------------------------------
    always_comb begin
        for (int g = 0; g < 4; g++) begin
            edge_g[g] = rise_r[g] ? (aln_r[src_r[g]] && !cprev_r[g])
                                  : (!aln_r[src_r[g]] && cprev_r[g]);
            word_g[g] = pack_word(mask_r[g], aln_r, sgn_r[g]);
        end
    end

    // clock history runs always, so enabling sees a settled level
    always_ff @(posedge clk) begin
        if (reset) begin
            cprev_r <= '0;
            for (int g = 0; g < 4; g++) begin
                trace_r[g] <= '0;
            end
        end else begin
            for (int g = 0; g < 4; g++) begin
                cprev_r[g] <= aln_r[src_r[g]];
                if (en_r[g] && (!clkd_r[g] || edge_g[g])) begin
                    trace_r[g] <= word_g[g];
                end
            end
        end
    end

    // -------------------------------------------------------------
    // decode entries: lowest group wins a shared edge
    // -------------------------------------------------------------
    always_comb begin
        push = 1'b0;
        lost = 1'b0;
        pg   = '0;
        for (int g = 3; g >= 0; g--) begin
            if (en_r[g] && clkd_r[g] && edge_g[g]) begin
                lost = lost | push;
                push = 1'b1;
                pg   = lcs_grp_t'(g);
            end
        end
        lost = lost | (push && !f_in_ready);
    end

    // sample timestamp and saturating loss counter
    always_ff @(posedge clk) begin
        if (reset) begin
            ts_r   <= '0;
            drop_r <= '0;
        end else begin
            ts_r <= ts_r + 16'd1;
            if (lost && drop_r != 16'hffff) begin
                drop_r <= drop_r + 16'd1;
            end
        end
    end

    lcs_fifo #(
        .W     (FW),
        .DEPTH (FDEPTH)
    ) u_fifo (
        .clk       (clk),
        .reset     (reset),
        .in_valid  (push),
        .in_ready  (f_in_ready),
        .in_data   ({pg, word_g[pg], ts_r}),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out_data)
    );

    // output stage keeps the decode port on flip-flops
    assign f_out_ready = !dv_r || decode_ready;

    always_ff @(posedge clk) begin
        if (reset) begin
            dv_r   <= 1'b0;
            dout_r <= '0;
        end else if (f_out_ready) begin
            dv_r <= f_out_valid;
            if (f_out_valid) begin
                dout_r <= f_out_data;
            end
        end
    end

    // -------------------------------------------------------------
    // register reads: data stands one cycle, zero otherwise
    // -------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset || !reg_rd) begin
            rdata_r <= '0;
        end else begin
            case (reg_addr[5:4])
                2'b00: begin
                    case (reg_addr)
                        `LCS_A_STATUS: rdata_r <= {4'h0, en_r, 6'h00,
                                                   preset_r == 2'd0, notice_r};
                        `LCS_A_COUPLE: rdata_r <= {15'h0000, couple_r};
                        `LCS_A_PRESET: rdata_r <= {14'h0000, preset_r};
                        `LCS_A_CSKEW:  rdata_r <= {12'h000, cskew_r};
                        `LCS_A_DROP:   rdata_r <= drop_r;
                        default:       rdata_r <= '0;
                    endcase
                end
                2'b01: begin
                    case (reg_addr[1:0])
                        `LCS_G_CTRL:  rdata_r <= {8'h00, src_r[wg], sgn_r[wg],
                                                  rise_r[wg], clkd_r[wg], en_r[wg]};
                        `LCS_G_MASK:  rdata_r <= mask_r[wg];
                        `LCS_G_THR:   rdata_r <= {6'h00, hys_r[wg], thr_r[wg]};
                        default:      rdata_r <= trace_r[wg];
                    endcase
                end
                2'b10:   rdata_r <= {12'h000, skew_r[reg_addr[3:0]]};
                default: rdata_r <= '0;
            endcase
        end
    end

    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    assign reg_rdata    = rdata_r;
    assign decode_valid = dv_r;
    assign decode_group = dout_r[33:32];
    assign decode_word  = dout_r[31:16];
    assign decode_time  = dout_r[15:0];
    assign notice       = notice_r;

    always_comb begin
        for (int g = 0; g < 4; g++) begin
            logic_group_trace[g] = trace_r[g];
        end
    end
endmodule

// ==== testbench/lcs_probe_model.sv ====
// probe model: logic levels of the system under test as 8-bit input codes
`timescale 1ns/10ps
module lcs_probe_model (
    input  wire logic [15:0] lv,
    output logic [63:0]      pod1,
    output logic [63:0]      pod2
);
    // codes far from every preset threshold, so hysteresis never hides a step
    always_comb begin
        for (int c = 0; c < 8; c++) begin
            pod1[c*8+:8] = lv[c] ? 8'hc0 : 8'h00;
            pod2[c*8+:8] = lv[c+8] ? 8'hc0 : 8'h00;
        end
    end
endmodule

// ==== testbench/lcs_sampler_properties.sv ====
// port-level properties of the logic channel sampler
`timescale 1ns/10ps
module lcs_sampler_checker (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [5:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        decode_valid,
    input wire logic        decode_ready,
    input wire logic [15:0] decode_word,
    input wire logic [15:0] decode_time,
    input wire logic        notice
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // one-cycle register accesses
    sequence wr_at(logic [5:0] a); reg_wr && reg_addr == a; endsequence
    sequence rd_at(logic [5:0] a); reg_rd && reg_addr == a; endsequence
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data not idle");
    notice_read_a: assert property (rd_at(6'h00) |=> reg_rdata[0] == $past(notice))
        else $error("status notice bit wrong");
    notice_hold_a: assert property (notice && !(reg_wr && reg_addr == 6'h00 && reg_wdata[0]) |=> notice)
        else $error("notice lost");
    notice_clear_a: assert property (wr_at(6'h00) ##0 reg_wdata[0] |=> !notice)
        else $error("notice not cleared");
    manual_on_a: assert property (wr_at(6'h02) ##0 reg_wdata[1:0] == 2'h0 ##1 rd_at(6'h00) |=> reg_rdata[1])
        else $error("manual flag missing");
    thr_manual_a: assert property (reg_wr && reg_addr[5:4] == 2'h1 && reg_addr[1:0] == 2'h2 ##1 rd_at(6'h00) |=> reg_rdata[1])
        else $error("threshold write kept preset");
    skew_back_a: assert property (reg_wr && reg_addr[5:4] == 2'h2 ##1 rd_at($past(reg_addr)) |=> reg_rdata[3:0] == $past(reg_wdata[3:0], 2))
        else $error("skew readback wrong");
    decode_hold_a: assert property (decode_valid && !decode_ready |=> decode_valid && $stable(decode_word) && $stable(decode_time))
        else $error("decode entry changed while stalled");
endmodule
bind lcs_sampler lcs_sampler_checker chk (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .decode_valid(decode_valid),
    .decode_ready(decode_ready), .decode_word(decode_word), .decode_time(decode_time), .notice(notice));

// ==== testbench/lcs_sampler_tb.sv ====
// self-checking bench for the logic channel sampler
`timescale 1ns/10ps
module lcs_sampler_tb;
    logic             clk, reset, reg_wr, reg_rd, decode_valid, decode_ready, notice;
    logic [15:0]      reg_wdata, reg_rdata, decode_word, decode_time, lv;
    logic [5:0]       reg_addr;
    logic [1:0]       decode_group;
    logic [63:0]      pod1, pod2;
    logic [3:0][15:0] trace;
    int               bad_count = 0;
    int               checks = 0;

    lcs_probe_model probe (.lv(lv), .pod1(pod1), .pod2(pod2));
    lcs_sampler dut (.clk(clk), .reset(reset), .first_pod_lines(pod1), .second_pod_lines(pod2),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .logic_group_trace(trace), .decode_valid(decode_valid), .decode_ready(decode_ready),
        .decode_group(decode_group), .decode_word(decode_word), .decode_time(decode_time), .notice(notice));

    // 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    // a strobe stays up into a following access, so no signal gets two values in one step
    task cyc(input int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge clk);
    endtask
    // callers sit just after an edge, so accesses run back to back
    task wr(input logic [5:0] a, input logic [15:0] d);
        reg_rd    <= 1'b0;
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
    endtask
    task rc(input logic [5:0] a, input logic [15:0] exp);
        reg_wr   <= 1'b0;
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        #1 cmp(reg_rdata, exp);
    endtask

    task t_regs;
        rc(6'h01, 16'h0001);
        wr(6'h02, 16'h0002);
        rc(6'h00, 16'h0000);
        rc(6'h02, 16'h0002);
        wr(6'h02, 16'h0000);
        rc(6'h00, 16'h0002);
        wr(6'h12, 16'h0012);
        rc(6'h1e, 16'h0012);
    endtask
    // level, packing order, per-channel and common delay
    task t_level;
        wr(6'h02, 16'h0001);
        wr(6'h11, 16'h8001);
        wr(6'h10, 16'h0001);
        lv <= 16'h8000;
        cyc(5);
        #1 cmp(trace[0], 16'h0000);
        cyc(3);
        #1 cmp(trace[0], 16'h0002);
        wr(6'h20, 16'h0004);
        rc(6'h20, 16'h0004);
        wr(6'h03, 16'h0002);
        lv <= 16'h0001;
        cyc(10);
        #1 cmp(trace[0], 16'h0000);
        cyc(4);
        #1 cmp(trace[0], 16'h0001);
    endtask
    // overlapping enable evicts, locked mask, pod buttons
    task t_conflict;
        wr(6'h15, 16'h0001);
        wr(6'h14, 16'h0001);
        rc(6'h00, 16'h0201);
        cmp(16'(notice), 16'h0001);
        wr(6'h00, 16'h0001);
        rc(6'h00, 16'h0200);
        cmp(16'(notice), 16'h0000);
        wr(6'h15, 16'hffff);
        rc(6'h15, 16'h0001);
        wr(6'h14, 16'h0000);
        wr(6'h05, 16'h0011);
        rc(6'h15, 16'hff01);
        wr(6'h05, 16'h0009);
        rc(6'h15, 16'hff00);
    endtask
    // six rising clock edges on channel 8 while the output stalls
    task t_clocked;
        int          n;
        logic [15:0] last;
        n = 0;
        last = 16'h0000;
        wr(6'h19, 16'h00f0);
        wr(6'h18, 16'h0087);
        for (int k = 1; k <= 6; k++) begin
            lv <= 16'(k << 4);
            cyc(4);
            lv <= 16'(k << 4) | 16'h0100;
            cyc(4);
        end
        lv <= 16'h0000;
        cyc(20);
        decode_ready <= 1'b1;
        repeat (30) begin
            @(negedge clk);
            if (decode_valid === 1'b1) begin
                n++;
                cmp(decode_word, 16'(n));
                cmp(16'(decode_group), 16'h0002);
                cmp(16'(decode_time > last), 16'h0001);
                last = decode_time;
            end
        end
        // the output stage and four fifo words survive the stall, the sixth is lost
        cmp(16'(n), 16'h0005);
        cmp(trace[2], 16'h0006);
        rc(6'h04, 16'h0001);
    endtask
    // two-channel signed group: channel 1 high sign-extends to minus two
    task t_signed;
        wr(6'h1d, 16'h0003);
        wr(6'h1c, 16'h0009);
        lv <= 16'h0002;
        cyc(12);
        #1 cmp(trace[3], 16'hfffe);
    endtask

    initial begin
        reset = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 6'h00;
        reg_wdata = 16'h0000;
        lv = 16'h0000;
        decode_ready = 1'b0;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        t_regs;
        t_level;
        t_conflict;
        t_clocked;
        t_signed;
        print_verdict;
    end
    // the whole run needs well under a thousand cycles
    initial begin
        #500000;
        bad_count++;
        print_verdict;
    end
    task print_verdict;
        if (bad_count == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
endmodule
